// file: design/nac_pkg.sv
package nac_pkg;
	// coprocessor 15 register keys: opcode1, primary, secondary, opcode2
	localparam logic [2:0]  GATE_OPC1      = 3'h0;
	localparam logic [3:0]  GATE_CRN       = 4'h1;
	localparam logic [3:0]  GATE_CRM       = 4'h1;
	localparam logic [2:0]  GATE_OPC2      = 3'h2;
	localparam logic [2:0]  AUX_OPC1       = 3'h0;
	localparam logic [3:0]  AUX_CRN        = 4'h1;
	localparam logic [3:0]  AUX_CRM        = 4'h0;
	localparam logic [2:0]  AUX_OPC2       = 3'h1;
	localparam logic [2:0]  CPAC_OPC1      = 3'h0;
	localparam logic [3:0]  CPAC_CRN       = 4'h1;
	localparam logic [3:0]  CPAC_CRM       = 4'h0;
	localparam logic [2:0]  CPAC_OPC2      = 3'h2;
	localparam logic [2:0]  MOVR_OPC1      = 3'h0;
	localparam logic [3:0]  MOVR_CRN       = 4'h1;
	localparam logic [3:0]  MOVR_CRM       = 4'h1;
	localparam logic [2:0]  MOVR_OPC2      = 3'h3;
	// access gate fields
	localparam int          GATE_MP_BIT    = 18;
	localparam int          GATE_VEC_BIT   = 15;
	localparam int          GATE_UPR_BIT   = 14;
	localparam int          GATE_COPROC11_PERMIT_BIT  = 11;
	localparam int          GATE_COPROC10_PERMIT_BIT  = 10;
	localparam logic [31:0] GATE_RW_MASK   = 32'h0004_cc00;
	localparam logic [31:0] GATE_RESET     = 32'h0000_0000;
	// access control register fields
	localparam int          CPAC_VEC_BIT   = 31;
	localparam int          CPAC_UPR_BIT   = 30;
	localparam int          CPAC_CP_LSB    = 20;
	localparam logic [3:0]  CPAC_CP_RESET  = 4'h0;
	// auxiliary control register field
	localparam int          AUX_MP_BIT     = 6;
	// mask override fields
	localparam int          MOVR_LSB       = 6;
	localparam logic [2:0]  MOVR_RESET     = 3'h0;
	// coprocessor numbers
	localparam logic [3:0]  CP_NUM10       = 4'ha;
	localparam logic [3:0]  CP_NUM11       = 4'hb;
endpackage

// file: design/nac_forced_bit.sv
`timescale 1ns/1ps
module nac_forced_bit (
	input  wire logic stored,
	input  wire logic wbit,
	input  wire logic wr,
	input  wire logic gate,
	input  wire logic nonsecure,
	output logic      view,
	output logic      nxt
);
	wire forced = gate & nonsecure;

	// forced bit reads one and swallows writes
	assign view = stored | forced;
	assign nxt  = (wr && !forced) ? wbit : stored;
endmodule

// file: design/nac_access_gate.sv
`timescale 1ns/1ps
// Functional notes
// - user mode access to gate is undefined
// - secure rw, nonsecure read only, else undefined
// - cp14 and cp15 permissions never gated
// - bit 18 clear traps nonsecure aux writes
// - bit 18 set lets nonsecure write mp only
// - vector gate forces disable bit in nonsecure
// - upper gate forces upper disable in nonsecure
// - coprocessor 11 nonsecure only when permitted
// - coprocessor 10 nonsecure only when permitted
// - gate key is 0, c1, c1, 2
// - mask override secure privileged only
module nac_access_gate
	import nac_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [2:0]  req_opc1,
	input  wire logic [3:0]  req_crn,
	input  wire logic [3:0]  req_crm,
	input  wire logic [2:0]  req_opc2,
	input  wire logic [31:0] req_wdata,
	input  wire logic        req_priv,
	input  wire logic        req_nonsecure,
	input  wire logic        cur_nonsecure,
	input  wire logic [3:0]  cp_query_num,
	output logic             rsp_valid_ff,
	output logic             rsp_undef_ff,
	output logic [31:0]      rsp_rdata_ff,
	output logic             multiprocessing_bit_ff,
	output logic             cp_query_ok_ff,
	output logic [2:0]       mask_override_ff,
	output logic             vec_disable_eff_ff,
	output logic             upper_disable_eff_ff
);
	logic [31:0] gate_ff;
	logic        vec_dis_ff;
	logic        upr_dis_ff;
	logic [3:0]  cpac_cp_ff;

	wire hit_gate = (req_opc1 == GATE_OPC1) && (req_crn == GATE_CRN)
		&& (req_crm == GATE_CRM) && (req_opc2 == GATE_OPC2);
	wire hit_aux  = (req_opc1 == AUX_OPC1) && (req_crn == AUX_CRN)
		&& (req_crm == AUX_CRM) && (req_opc2 == AUX_OPC2);
	wire hit_cpac = (req_opc1 == CPAC_OPC1) && (req_crn == CPAC_CRN)
		&& (req_crm == CPAC_CRM) && (req_opc2 == CPAC_OPC2);
	wire hit_movr = (req_opc1 == MOVR_OPC1) && (req_crn == MOVR_CRN)
		&& (req_crm == MOVR_CRM) && (req_opc2 == MOVR_OPC2);

	wire user     = !req_priv;
	wire ns_wr    = req_nonsecure && req_write;
	wire mp_gate  = gate_ff[GATE_MP_BIT];
	wire vec_gate = gate_ff[GATE_VEC_BIT];
	wire upr_gate = gate_ff[GATE_UPR_BIT];

	wire undef_gate = user || ns_wr;
	wire undef_aux  = user || (ns_wr && !mp_gate);
	wire undef_cpac = user;
	wire undef_movr = user || req_nonsecure;

	// unmapped keys are treated as undefined, never silently absorbed
	wire nxt_undef = hit_gate ? undef_gate :
		hit_aux  ? undef_aux :
		hit_cpac ? undef_cpac :
		hit_movr ? undef_movr : 1'b1;
	wire do_wr = req_valid && req_write && !nxt_undef;

	wire [31:0] nxt_gate = (do_wr && hit_gate) ? (req_wdata & GATE_RW_MASK) : gate_ff;
	// nonsecure write reaches only the mp bit; other aux bits are not held
	wire nxt_mp = (do_wr && hit_aux) ? req_wdata[AUX_MP_BIT] : multiprocessing_bit_ff;
	wire [3:0] nxt_cpac_cp = (do_wr && hit_cpac) ? req_wdata[CPAC_CP_LSB +: 4] : cpac_cp_ff;
	wire [2:0] nxt_movr = (do_wr && hit_movr) ? req_wdata[MOVR_LSB +: 3] : mask_override_ff;

	logic vec_view;
	logic nxt_vec;
	logic upr_view;
	logic nxt_upr;

	nac_forced_bit u_vec (
		.stored    (vec_dis_ff),
		.wbit      (req_wdata[CPAC_VEC_BIT]),
		.wr        (do_wr && hit_cpac),
		.gate      (vec_gate),
		.nonsecure (req_nonsecure),
		.view      (vec_view),
		.nxt       (nxt_vec)
	);

	nac_forced_bit u_upr (
		.stored    (upr_dis_ff),
		.wbit      (req_wdata[CPAC_UPR_BIT]),
		.wr        (do_wr && hit_cpac),
		.gate      (upr_gate),
		.nonsecure (req_nonsecure),
		.view      (upr_view),
		.nxt       (nxt_upr)
	);

	wire [31:0] cpac_rd = {vec_view, upr_view, 6'h00, cpac_cp_ff, 20'h0_0000};
	wire [31:0] aux_rd  = 32'(multiprocessing_bit_ff) << AUX_MP_BIT;
	wire [31:0] movr_rd = 32'(mask_override_ff) << MOVR_LSB;
	wire [31:0] nxt_rdata = (req_valid && !req_write && !nxt_undef) ?
		(hit_gate ? gate_ff : hit_aux ? aux_rd : hit_cpac ? cpac_rd : movr_rd) : 32'h0000_0000;

	// only coprocessors 10 and 11 are gated; all others pass untouched
	wire nxt_cp_ok = (cp_query_num == CP_NUM11) ? (!cur_nonsecure || gate_ff[GATE_COPROC11_PERMIT_BIT]) :
		(cp_query_num == CP_NUM10) ? (!cur_nonsecure || gate_ff[GATE_COPROC10_PERMIT_BIT]) : 1'b1;
	wire nxt_vec_eff = vec_dis_ff || (vec_gate && cur_nonsecure);
	wire nxt_upr_eff = upr_dis_ff || (upr_gate && cur_nonsecure);

	always_ff @(posedge clock) begin
		if (reset) begin
			gate_ff <= GATE_RESET;
			multiprocessing_bit_ff <= 1'b0;
			vec_dis_ff <= 1'b0;
			upr_dis_ff <= 1'b0;
			cpac_cp_ff <= CPAC_CP_RESET;
			mask_override_ff <= MOVR_RESET;
		end else begin
			gate_ff <= nxt_gate;
			multiprocessing_bit_ff <= nxt_mp;
			vec_dis_ff <= nxt_vec;
			upr_dis_ff <= nxt_upr;
			cpac_cp_ff <= nxt_cpac_cp;
			mask_override_ff <= nxt_movr;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rsp_valid_ff <= 1'b0;
			rsp_undef_ff <= 1'b0;
			rsp_rdata_ff <= 32'h0000_0000;
			cp_query_ok_ff <= 1'b0;
			vec_disable_eff_ff <= 1'b0;
			upper_disable_eff_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= req_valid;
			rsp_undef_ff <= req_valid && nxt_undef;
			rsp_rdata_ff <= nxt_rdata;
			cp_query_ok_ff <= nxt_cp_ok;
			vec_disable_eff_ff <= nxt_vec_eff;
			upper_disable_eff_ff <= nxt_upr_eff;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	user_undef_a: assert property (
		req_valid && !req_priv |=> rsp_valid_ff && rsp_undef_ff)
		else $error("user access not undefined");
	ns_gate_wr_a: assert property (
		req_valid && hit_gate && req_write && req_nonsecure |=> rsp_undef_ff && $stable(gate_ff))
		else $error("nonsecure gate write not refused");
	cp15_free_a: assert property (
		cp_query_num == 4'hf |=> cp_query_ok_ff)
		else $error("cp15 access gated");
	mp_trap_a: assert property (
		req_valid && hit_aux && req_write && req_priv && req_nonsecure && !mp_gate
		|=> rsp_undef_ff && $stable(multiprocessing_bit_ff))
		else $error("mp write not trapped");
	mp_update_a: assert property (
		req_valid && hit_aux && req_write && req_priv && req_nonsecure && mp_gate
		|=> !rsp_undef_ff && multiprocessing_bit_ff == $past(req_wdata[AUX_MP_BIT]))
		else $error("mp write lost");
	vec_force_a: assert property (
		req_valid && hit_cpac && !req_write && req_priv && req_nonsecure && vec_gate
		|=> rsp_rdata_ff[CPAC_VEC_BIT])
		else $error("vector disable not forced");
	upr_force_a: assert property (
		cur_nonsecure && upr_gate |=> upper_disable_eff_ff)
		else $error("upper disable not forced");
	coproc11_permit_block_a: assert property (
		cp_query_num == CP_NUM11 && cur_nonsecure && !gate_ff[GATE_COPROC11_PERMIT_BIT] |=> !cp_query_ok_ff)
		else $error("coproc11_permit not blocked");
	coproc10_permit_block_a: assert property (
		cp_query_num == CP_NUM10 && cur_nonsecure && !gate_ff[GATE_COPROC10_PERMIT_BIT] |=> !cp_query_ok_ff)
		else $error("coproc10_permit not blocked");
	gate_read_a: assert property (
		req_valid && hit_gate && !req_write && req_priv |=> !rsp_undef_ff && rsp_rdata_ff == $past(gate_ff))
		else $error("gate read wrong");
	movr_ns_a: assert property (
		req_valid && hit_movr && req_nonsecure |=> rsp_undef_ff && $stable(mask_override_ff))
		else $error("mask override reached from nonsecure");
	gate_rsvd_a: assert property (
		(gate_ff & ~GATE_RW_MASK) == 32'h0000_0000)
		else $error("reserved gate bit set");

	// secure writes must land, masked to the writable gate bits
	gate_write_a: assert property (
		req_valid && hit_gate && req_write && req_priv && !req_nonsecure
		|=> !rsp_undef_ff && gate_ff == ($past(req_wdata) & GATE_RW_MASK))
		else $error("secure gate write lost");
	cp14_free_a: assert property (
		cp_query_num == 4'he |=> cp_query_ok_ff)
		else $error("cp14 access gated");
	aux_read_a: assert property (
		req_valid && hit_aux && !req_write && req_priv |=> rsp_rdata_ff[AUX_MP_BIT] == $past(multiprocessing_bit_ff)
		&& rsp_rdata_ff[31:AUX_MP_BIT+1] == '0 && rsp_rdata_ff[AUX_MP_BIT-1:0] == '0)
		else $error("aux read shows more than the mp bit");
	// a swallowed write must not leak into the stored disable bits
	vec_keep_a: assert property (
		req_valid && hit_cpac && req_write && req_priv && req_nonsecure && vec_gate |=> $stable(vec_dis_ff))
		else $error("forced vector disable bit written");
	upr_keep_a: assert property (
		req_valid && hit_cpac && req_write && req_priv && req_nonsecure && upr_gate |=> $stable(upr_dis_ff))
		else $error("forced upper disable bit written");
	coproc11_permit_secure_a: assert property (
		cp_query_num == CP_NUM11 && !cur_nonsecure |=> cp_query_ok_ff)
		else $error("coproc11_permit refused in secure state");
	coproc10_permit_secure_a: assert property (
		cp_query_num == CP_NUM10 && !cur_nonsecure |=> cp_query_ok_ff)
		else $error("coproc10_permit refused in secure state");
	unmapped_key_a: assert property (
		req_valid && !(hit_gate || hit_aux || hit_cpac || hit_movr) |=> rsp_undef_ff)
		else $error("unmapped key not undefined");

	sec_gate_wr_c: cover property (req_valid && hit_gate && req_write && req_priv && !req_nonsecure);
	ns_mp_wr_c: cover property (req_valid && hit_aux && req_write && req_nonsecure && mp_gate);
	ns_coproc10_permit_ok_c: cover property (cp_query_num == CP_NUM10 && cur_nonsecure && gate_ff[GATE_COPROC10_PERMIT_BIT]);
	vec_forced_c: cover property (req_valid && hit_cpac && req_write && req_nonsecure && vec_gate);
	movr_sec_wr_c: cover property (req_valid && hit_movr && req_write && req_priv && !req_nonsecure);
endmodule

// file: test/nonsecure_access_control_test.sv
`timescale 1ns/1ps
module nonsecure_access_control_test;
	import nac_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        req_valid = 1'b0, req_write = 1'b0, req_priv = 1'b0, req_nonsecure = 1'b0;
	logic        cur_nonsecure = 1'b0;
	logic [2:0]  req_opc1 = 3'h0, req_opc2 = 3'h0;
	logic [3:0]  req_crn = 4'h0, req_crm = 4'h0, cp_query_num = 4'h0;
	logic [31:0] req_wdata = 32'h0, rsp_rdata_ff;
	logic        rsp_valid_ff, rsp_undef_ff, multiprocessing_bit_ff, cp_query_ok_ff;
	logic        vec_disable_eff_ff, upper_disable_eff_ff;
	logic [2:0]  mask_override_ff;
	// bench model of the register state
	logic [31:0] m_gate = 32'h0, m_cpac = 32'h0;
	logic        m_mp = 1'b0;
	logic [2:0]  m_movr = 3'h0;
	int          miscompares = 0, cmp_count = 0;

	nac_access_gate nac_access_gate_i (.clock(clock), .reset(reset), .req_valid(req_valid), .req_write(req_write),
		.req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2), .req_wdata(req_wdata),
		.req_priv(req_priv), .req_nonsecure(req_nonsecure), .cur_nonsecure(cur_nonsecure),
		.cp_query_num(cp_query_num), .rsp_valid_ff(rsp_valid_ff), .rsp_undef_ff(rsp_undef_ff),
		.rsp_rdata_ff(rsp_rdata_ff), .multiprocessing_bit_ff(multiprocessing_bit_ff),
		.cp_query_ok_ff(cp_query_ok_ff), .mask_override_ff(mask_override_ff),
		.vec_disable_eff_ff(vec_disable_eff_ff), .upper_disable_eff_ff(upper_disable_eff_ff));

	always #5 clock = ~clock;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// key 4 is an unmapped key
	task automatic access(input logic wr, input int key, input logic [31:0] wd, input logic priv, input logic ns);
		logic        undef;
		logic [31:0] rd, nv;
		undef = !priv || key == 4 || (key == 0 && ns && wr) || (key == 1 && ns && wr && !m_gate[18]) ||
			(key == 3 && ns);
		rd = 32'h0;
		nv = {wd[31], wd[30], 6'h0, wd[23:20], 20'h0};
		if (ns && m_gate[15])
			nv[31] = m_cpac[31];
		if (ns && m_gate[14])
			nv[30] = m_cpac[30];
		if (!undef && !wr) begin
			case (key)
				0: rd = m_gate;
				1: rd = {25'h0, m_mp, 6'h0};
				2: rd = m_cpac | {ns && m_gate[15], ns && m_gate[14], 30'h0};
				default: rd = {23'h0, m_movr, 6'h0};
			endcase
		end
		if (!undef && wr) begin
			case (key)
				0: m_gate = wd & GATE_RW_MASK;
				1: m_mp = wd[6];
				2: m_cpac = nv;
				default: m_movr = wd[8:6];
			endcase
		end
		@(negedge clock);
		req_valid = 1'b1;
		req_write = wr;
		req_wdata = wd;
		req_priv = priv;
		req_nonsecure = ns;
		case (key)
			0: {req_opc1, req_crn, req_crm, req_opc2} = {GATE_OPC1, GATE_CRN, GATE_CRM, GATE_OPC2};
			1: {req_opc1, req_crn, req_crm, req_opc2} = {AUX_OPC1, AUX_CRN, AUX_CRM, AUX_OPC2};
			2: {req_opc1, req_crn, req_crm, req_opc2} = {CPAC_OPC1, CPAC_CRN, CPAC_CRM, CPAC_OPC2};
			3: {req_opc1, req_crn, req_crm, req_opc2} = {MOVR_OPC1, MOVR_CRN, MOVR_CRM, MOVR_OPC2};
			default: {req_opc1, req_crn, req_crm, req_opc2} = {3'h0, 4'hf, 4'h1, 3'h5};
		endcase
		@(negedge clock);
		req_valid = 1'b0;
		check("rsp_valid", {31'h0, rsp_valid_ff}, 32'h1);
		check("rsp_undef", {31'h0, rsp_undef_ff}, {31'h0, undef});
		check("rsp_rdata", rsp_rdata_ff, rd);
		check("mp_bit", {31'h0, multiprocessing_bit_ff}, {31'h0, m_mp});
		check("mask_override", {29'h0, mask_override_ff}, {29'h0, m_movr});
	endtask

	task automatic query();
		logic okx;
		@(negedge clock);
		cp_query_num = 4'($urandom);
		cur_nonsecure = 1'($urandom);
		okx = (cp_query_num == CP_NUM10) ? (!cur_nonsecure || m_gate[10]) :
			(cp_query_num == CP_NUM11) ? (!cur_nonsecure || m_gate[11]) : 1'b1;
		repeat (2) @(negedge clock);
		check("cp_query_ok", {31'h0, cp_query_ok_ff}, {31'h0, okx});
		check("vec_eff", {31'h0, vec_disable_eff_ff}, {31'h0, (cur_nonsecure && m_gate[15]) || m_cpac[31]});
		check("upr_eff", {31'h0, upper_disable_eff_ff}, {31'h0, (cur_nonsecure && m_gate[14]) || m_cpac[30]});
	endtask

	initial begin
		void'($urandom(32'hec40e20c));
		repeat (2) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		access(1'b0, 0, 32'h0, 1'b1, 1'b0);
		access(1'b1, 1, 32'hffff_ffff, 1'b1, 1'b1);
		access(1'b1, 0, 32'hffff_ffff, 1'b1, 1'b0);
		access(1'b0, 0, 32'h0, 1'b1, 1'b1);
		access(1'b1, 0, 32'h0, 1'b1, 1'b1);
		access(1'b0, 0, 32'h0, 1'b0, 1'b0);
		access(1'b1, 1, 32'hffff_ffff, 1'b1, 1'b1);
		access(1'b0, 1, 32'h0, 1'b1, 1'b1);
		access(1'b1, 2, 32'hffff_ffff, 1'b1, 1'b1);
		access(1'b0, 2, 32'h0, 1'b1, 1'b1);
		access(1'b0, 2, 32'h0, 1'b1, 1'b0);
		query();
		$display("directed test done");
		// random traffic mostly privileged, so state changes often
		repeat (400) begin
			access(1'($urandom), int'($urandom % 5), $urandom, ($urandom % 4) != 0, 1'($urandom));
			query();
		end
		$display("random test done");
		report_and_stop();
	end

	// about 2030 cycles expected; generous margin
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end
endmodule
